// ==== adc_pin_defines.svh ====
`ifndef ADC_PIN_DEFINES_SVH
`define ADC_PIN_DEFINES_SVH

// Register byte offsets on the APB bus
`define OFS_PORT_DATA        8'h00
`define OFS_PORT_DIR         8'h04
`define OFS_PORT_PINS        8'h08
`define OFS_ADC_STATUS_CTRL  8'h3c
`define OFS_ADC_DATA         8'h40
`define OFS_ADC_CLK_SEL      8'h44
`define OFS_IRQ_STATUS       8'h48
`define OFS_IRQ_MASK         8'h4c

// Fields of adc_status_control
`define ASC_COCO_BIT         7
`define ASC_AIEN_BIT         6
`define ASC_CONT_BIT         5
`define ASC_CH_MSB           2
`define ASC_CH_LSB           0

// Reset values
`define RST_ADC_STATUS_CTRL  8'h07
`define RST_PORT_DATA        4'h0
`define RST_PORT_DIR         4'h0
`define RST_ADC_DATA         8'h00
`define RST_ADC_CLK_SEL      2'h0
`define RST_IRQ_MASK         1'h0

// Channel codes; codes at or above this switch the converter off
`define CH_OFF_LIMIT         3'h4

// Timing: one converter clock is BASE cycles shifted left by the clock select
`define ADC_TICK_BASE        8'h04
`define ADC_MSB_INDEX        3'h7

`endif

// ==== adc_pin_pkg.sv ====
package adc_pin_pkg;

    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_RUN
    } conv_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [3:0] pin_out;
        logic [3:0] pin_oe;
    } pin_drive_t;

endpackage

// ==== adc_channel_pin_control.sv ====
`timescale 1ns/10ps
`include "adc_pin_defines.svh"

// Notes on behaviour
// RULE1 - Four analog channels; a multiplexer routes exactly one to the converter.
// RULE2 - Every conversion result is an unsigned eight-bit value.
// RULE3 - Linear successive approximation from the top bit down, monotonic codes.
// RULE4 - Single conversion then stop, or continuous back-to-back conversions.
// RULE5 - On finish, load the data register, then set flag or raise interrupt.
// RULE6 - Software selects the converter clock rate from several settings.
// RULE7 - Channels 0..3 sample port A bits 0, 1, 4 and 5; the code maps channel n to bit n of its four-bit port instead.
// RULE8 - Channel select bits of the status/control register at 0x3c pick the pin.
// RULE9 - The selected pin is forced to input, overriding port logic.
// RULE10 - Unselected shared pins stay ordinary general-purpose inputs or outputs.
// RULE11 - Port data and direction writes leave the selected pin unaffected.
// RULE12 - Reading the selected pin returns 0 when its direction bit is 0.
// RULE13 - Reading the selected pin returns the output latch when direction is 1.
// RULE14 - Interrupt-enable bit chooses interrupt request or completion flag polling.
module adc_channel_pin_control
    import adc_pin_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   reset,
    input  wire logic                   clk_en,
    input  wire adc_pin_pkg::apb_req_t  apb_req,
    output adc_pin_pkg::apb_rsp_t       apb_rsp,
    input  wire logic [3:0]             pin_in,
    output adc_pin_pkg::pin_drive_t     pin_drive,
    output logic [3:0]                  selected_analog_input,
    output logic [7:0]                  dac_code,
    input  wire logic                   comp_above,
    output logic                        conv_busy,
    output logic                        irq
);
    import adc_pin_pkg::*;

    typedef struct packed {
        logic [3:0]  port_data;
        logic [3:0]  port_dir;
        logic [2:0]  ch;
        logic        aien;
        logic        cont;
        logic        coco;
        logic [7:0]  adc_data;
        logic [1:0]  clk_sel;
        logic        irq_sts;
        logic        irq_mask;
        logic [7:0]  div_cnt;
        logic [2:0]  bit_idx;
        logic [7:0]  sar;
        conv_state_t conv;
        logic [3:0]  pin_s1;
        logic [3:0]  pin_s2;
        logic        comp_s1;
        logic        comp_s2;
        apb_rsp_t    rsp;
        pin_drive_t  drive;
        logic [3:0]  mux_sel;
        logic        busy;
        logic        irq;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    // One-hot pin mask of a channel code; zero when the converter is off
    function automatic logic [3:0] chan_mask(input logic [2:0] ch);
        logic [3:0] m;
        m = 4'h0;
        if (ch < `CH_OFF_LIMIT)
        begin
            m[ch[1:0]] = 1'b1;
        end
        return m;
    endfunction

    // Port value seen by software, with the converter pin substituted
    function automatic logic [3:0] port_view(input logic [3:0] data,
                                             input logic [3:0] dir,
                                             input logic [3:0] pins,
                                             input logic [3:0] sel);
        logic [3:0] v;
        v = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                v[i] = dir[i] ? data[i] : 1'b0;
            end
            else
            begin
                v[i] = dir[i] ? data[i] : pins[i];
            end
        end
        return v;
    endfunction

    // Converter clock period in bus cycles for a clock select
    function automatic logic [7:0] tick_period(input logic [1:0] sel);
        return 8'(`ADC_TICK_BASE << sel);
    endfunction

    logic [3:0] sel_mask;
    logic       access;
    logic       wr_take;
    logic       rd_take;
    logic       asc_wr;
    logic [7:0] asc_val;

    always_comb
    begin
        sel_mask  = chan_mask(state_r.ch);
        access    = apb_req.psel & apb_req.penable;
        wr_take   = access & apb_req.pwrite & state_r.rsp.pready;
        rd_take   = access & ~apb_req.pwrite & state_r.rsp.pready;
        asc_wr    = wr_take & (apb_req.paddr == `OFS_ADC_STATUS_CTRL);
        asc_val   = {state_r.coco, state_r.aien, state_r.cont, 2'h0, state_r.ch};
        state_nxt = state_r;

        // Pin inputs pass two flops before use
        state_nxt.pin_s1  = pin_in;
        state_nxt.pin_s2  = state_r.pin_s1;
        state_nxt.comp_s1 = comp_above;
        state_nxt.comp_s2 = state_r.comp_s1;

        // APB: ready one cycle into the access phase, dropped after the handshake
        // A write lands only at the edge that samples pready high
        state_nxt.rsp.pready  = 1'b0;
        state_nxt.rsp.pslverr = 1'b0;
        if (access & ~state_r.rsp.pready)
        begin
            state_nxt.rsp.pready = 1'b1;
            state_nxt.rsp.prdata = 32'h0;
            unique case (apb_req.paddr)
                `OFS_PORT_DATA:
                    state_nxt.rsp.prdata[3:0] = state_r.port_data;
                `OFS_PORT_DIR:
                    state_nxt.rsp.prdata[3:0] = state_r.port_dir;
                // RULE12 selected pin reads 0
                // RULE13 or its latch
                `OFS_PORT_PINS:
                    state_nxt.rsp.prdata[3:0] = port_view(state_r.port_data, state_r.port_dir,
                                                          state_r.pin_s2, sel_mask);
                `OFS_ADC_STATUS_CTRL:
                    state_nxt.rsp.prdata[7:0] = asc_val;
                `OFS_ADC_DATA:
                    state_nxt.rsp.prdata[7:0] = state_r.adc_data;
                `OFS_ADC_CLK_SEL:
                    state_nxt.rsp.prdata[1:0] = state_r.clk_sel;
                `OFS_IRQ_STATUS:
                    state_nxt.rsp.prdata[0] = state_r.irq_sts;
                `OFS_IRQ_MASK:
                    state_nxt.rsp.prdata[0] = state_r.irq_mask;
                // Unmapped addresses answer with an error and read as zero
                default:
                    state_nxt.rsp.pslverr = 1'b1;
            endcase
        end

        // Reading the result acknowledges the completion flag
        // A completion in the same cycle wins: it is evaluated further down
        if (rd_take & (apb_req.paddr == `OFS_ADC_DATA))
        begin
            state_nxt.coco = 1'b0;
        end

        if (wr_take)
        begin
            unique case (apb_req.paddr)
                // RULE11 selected pin keeps its bits
                `OFS_PORT_DATA:
                    state_nxt.port_data = (state_r.port_data & sel_mask)
                                        | (apb_req.pwdata[3:0] & ~sel_mask);
                `OFS_PORT_DIR:
                    state_nxt.port_dir = (state_r.port_dir & sel_mask)
                                       | (apb_req.pwdata[3:0] & ~sel_mask);
                // RULE6 converter clock select
                `OFS_ADC_CLK_SEL:
                    state_nxt.clk_sel = apb_req.pwdata[1:0];
                `OFS_IRQ_MASK:
                    state_nxt.irq_mask = apb_req.pwdata[0];
                `OFS_IRQ_STATUS:
                    state_nxt.irq_sts = state_r.irq_sts & ~apb_req.pwdata[0];
                default:
                begin
                end
            endcase
        end

        // A status write aborts any conversion in flight
        // RULE8 channel select write starts a conversion
        if (asc_wr)
        begin
            state_nxt.aien    = apb_req.pwdata[`ASC_AIEN_BIT];
            state_nxt.cont    = apb_req.pwdata[`ASC_CONT_BIT];
            state_nxt.ch      = apb_req.pwdata[`ASC_CH_MSB:`ASC_CH_LSB];
            state_nxt.coco    = 1'b0;
            state_nxt.div_cnt = 8'h0;
            state_nxt.bit_idx = `ADC_MSB_INDEX;
            state_nxt.sar     = 8'h80;
            state_nxt.conv    = (apb_req.pwdata[`ASC_CH_MSB:`ASC_CH_LSB] < `CH_OFF_LIMIT)
                              ? CONV_RUN : CONV_IDLE;
        end
        else
        begin
            unique case (state_r.conv)
                CONV_IDLE:
                begin
                    state_nxt.div_cnt = 8'h0;
                end
                CONV_RUN:
                begin
                    // RULE6 one decision per converter clock
                    if (state_r.div_cnt != 8'(tick_period(state_r.clk_sel) - 8'h1))
                    begin
                        state_nxt.div_cnt = 8'(state_r.div_cnt + 8'h1);
                    end
                    else
                    begin
                        state_nxt.div_cnt = 8'h0;
                        // RULE3 keep or drop the trial bit, then try the next one
                        if (!state_r.comp_s2)
                        begin
                            state_nxt.sar[state_r.bit_idx] = 1'b0;
                        end
                        if (state_r.bit_idx != 3'h0)
                        begin
                            state_nxt.bit_idx = 3'(state_r.bit_idx - 3'h1);
                            state_nxt.sar[3'(state_r.bit_idx - 3'h1)] = 1'b1;
                        end
                        else
                        begin
                            // RULE2 eight-bit result
                            // RULE5 load data register
                            state_nxt.adc_data = state_nxt.sar;
                            // RULE14 interrupt or polled flag
                            if (state_r.aien)
                            begin
                                state_nxt.irq_sts = 1'b1;
                            end
                            else
                            begin
                                state_nxt.coco = 1'b1;
                            end
                            // RULE4 continuous restarts, single stops
                            state_nxt.bit_idx = `ADC_MSB_INDEX;
                            state_nxt.sar     = 8'h80;
                            state_nxt.conv    = state_r.cont ? CONV_RUN : CONV_IDLE;
                        end
                    end
                end
                // Unused state codes fall back to idle
                default:
                begin
                    state_nxt.conv = CONV_IDLE;
                end
            endcase
        end

        // Outputs are built from the next state so they leave flops directly
        // RULE1 one channel routed to the converter
        // RULE7 channel n on bit n of the four-bit port, not port A bits 0, 1, 4, 5
        state_nxt.mux_sel = chan_mask(state_nxt.ch);
        // RULE9 selected pin forced to input
        // RULE10 others follow port logic
        state_nxt.drive.pin_oe  = state_nxt.port_dir & ~state_nxt.mux_sel;
        state_nxt.drive.pin_out = state_nxt.port_data;
        state_nxt.busy          = (state_nxt.conv == CONV_RUN);
        state_nxt.irq           = state_nxt.irq_sts & state_nxt.irq_mask;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_r           <= '0;
            state_r.port_data <= `RST_PORT_DATA;
            state_r.port_dir  <= `RST_PORT_DIR;
            // Status fields start from the packed reset value of the register
            state_r.ch        <= 3'(`RST_ADC_STATUS_CTRL >> `ASC_CH_LSB);
            state_r.aien      <= 1'(`RST_ADC_STATUS_CTRL >> `ASC_AIEN_BIT);
            state_r.cont      <= 1'(`RST_ADC_STATUS_CTRL >> `ASC_CONT_BIT);
            state_r.coco      <= 1'(`RST_ADC_STATUS_CTRL >> `ASC_COCO_BIT);
            state_r.adc_data  <= `RST_ADC_DATA;
            state_r.clk_sel   <= `RST_ADC_CLK_SEL;
            state_r.irq_mask  <= `RST_IRQ_MASK;
            state_r.bit_idx   <= `ADC_MSB_INDEX;
            state_r.sar       <= 8'h80;
            state_r.conv      <= CONV_IDLE;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
        end
    end

    assign apb_rsp               = state_r.rsp;
    assign pin_drive             = state_r.drive;
    assign selected_analog_input = state_r.mux_sel;
    assign dac_code              = state_r.sar;
    assign conv_busy             = state_r.busy;
    assign irq                   = state_r.irq;

endmodule // adc_channel_pin_control

// ==== adc_pin_checker_sva.sv ====
`timescale 1ns/10ps
module adc_pin_checker
    import adc_pin_pkg::*;
(
    input wire logic                    clk_sys,
    input wire logic                    reset,
    input wire logic                    clk_en,
    input wire adc_pin_pkg::apb_req_t   apb_req,
    input wire adc_pin_pkg::apb_rsp_t   apb_rsp,
    input wire adc_pin_pkg::pin_drive_t pin_drive,
    input wire logic [3:0]              selected_analog_input,
    input wire logic [7:0]              dac_code,
    input wire logic                    conv_busy,
    input wire logic                    irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_mux_onehot;
        $onehot0(selected_analog_input);
    endproperty
    a_mux_onehot: assert property (p_mux_onehot) else $error("mux select not one-hot");
    property p_sel_input;
        (pin_drive.pin_oe & selected_analog_input) == 4'h0;
    endproperty
    a_sel_input: assert property (p_sel_input) else $error("selected pin driven");
    property p_start_top;
        $rose(conv_busy) |-> dac_code == 8'h80;
    endproperty
    a_start_top: assert property (p_start_top) else $error("trial code not 0x80 at start");
    property p_min_length;
        $rose(conv_busy) |-> conv_busy [*8];
    endproperty
    a_min_length: assert property (p_min_length) else $error("conversion too short");
    property p_busy_sel;
        conv_busy |-> selected_analog_input != 4'h0;
    endproperty
    a_busy_sel: assert property (p_busy_sel) else $error("busy with no channel");
    property p_latch_kept;
        (selected_analog_input == $past(selected_analog_input))
            |-> ((pin_drive.pin_out ^ $past(pin_drive.pin_out)) & selected_analog_input) == 4'h0;
    endproperty
    a_latch_kept: assert property (p_latch_kept) else $error("selected pin latch changed");
    property p_ready_pulse;
        apb_rsp.pready |=> !apb_rsp.pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    property p_ready_cause;
        apb_rsp.pready |-> $past(apb_req.psel && apb_req.penable);
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
    property p_err_ready;
        apb_rsp.pslverr |-> apb_rsp.pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_freeze;
        !clk_en |=> $stable(dac_code) && $stable(conv_busy);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with clk_en low");

    c_done: cover property ($fell(conv_busy));
    c_irq: cover property ($rose(irq));
    c_err: cover property (apb_rsp.pslverr);
endmodule // adc_pin_checker

bind adc_channel_pin_control adc_pin_checker adc_pin_checker_inst (.clk_sys, .reset, .clk_en, .apb_req,
    .apb_rsp, .pin_drive, .selected_analog_input, .dac_code, .conv_busy, .irq);

// ==== adc_source_model.sv ====
`timescale 1ns/10ps
module adc_source_model
    import adc_pin_pkg::*;
(
    input wire logic [3:0]              selected_analog_input,
    input wire logic [7:0]              dac_code,
    input wire adc_pin_pkg::pin_drive_t pin_drive,
    input wire logic [3:0]              ext_level,
    input wire logic [31:0]             levels,
    output logic                        comp_above,
    output logic [3:0]                  pin_in
);
    // Comparator floats when no channel is routed: drive the inverse of the trial code's low bit
    always_comb
    begin
        comp_above = ~dac_code[0];
        for (int i = 0; i < 4; i++)
            if (selected_analog_input[i])
                comp_above = (levels[8*i +: 8] >= dac_code);
        pin_in = (pin_drive.pin_oe & pin_drive.pin_out) | (~pin_drive.pin_oe & ext_level);
    end
endmodule // adc_source_model

// ==== adc_channel_pin_control_tb.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module adc_channel_pin_control_tb;
    import adc_pin_pkg::*;
    logic        clk_sys, reset, clk_en, comp_above, conv_busy, irq, err;
    apb_req_t    apb_req;
    apb_rsp_t    apb_rsp;
    pin_drive_t  pin_drive;
    logic [3:0]  pin_in, selected_analog_input;
    logic [7:0]  dac_code;
    logic [31:0] q;
    logic [31:0] levels = 32'h815aff00;
    int          mismatches, checked, cycles, n;

    adc_channel_pin_control adc_channel_pin_control_inst (.clk_sys, .reset, .clk_en, .apb_req, .apb_rsp,
        .pin_in, .pin_drive, .selected_analog_input, .dac_code, .comp_above, .conv_busy, .irq);
    adc_source_model adc_source_model_inst (.selected_analog_input, .dac_code, .pin_drive,
        .ext_level(4'hf), .levels, .comp_above, .pin_in);

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task summarize;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            $display("unexpected timeout");
            summarize;
        end
    end

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0);
        `CHK(nm, e, q)
    endtask
    task settle;
        repeat (2) @(negedge clk_sys);
    endtask
    task wait_idle(input int t);
        repeat (3) @(negedge clk_sys);
        n = 0;
        while (conv_busy !== 1'b0 && n < 2000)
        begin
            @(negedge clk_sys);
            n++;
        end
        `CHK("conversion time", 1'b1, n >= t - 6 && n <= t + 4)
    endtask

    initial
    begin
        reset = 1'b1;
        clk_en = 1'b1;
        apb_req = '0;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        rd(8'h3c, 32'h07, "status reset");
        rd(8'h40, 32'h00, "data reset");
        rd(8'h10, 32'h00, "unmapped");
        `CHK("pslverr", 1'b1, err)
        $display("test registers done");
        wr(8'h04, 32'hf);
        wr(8'h00, 32'ha);
        rd(8'h08, 32'ha, "pins off");
        wr(8'h3c, 32'h01);
        settle;
        `CHK("mux", 4'h2, selected_analog_input)
        `CHK("oe", 4'hd, pin_drive.pin_oe)
        rd(8'h08, 32'ha, "pins latch");
        wr(8'h00, 32'h5);
        wr(8'h04, 32'h0);
        settle;
        `CHK("out", 4'h7, pin_drive.pin_out)
        `CHK("oe kept", 4'h0, pin_drive.pin_oe)
        wr(8'h3c, 32'h07);
        wr(8'h04, 32'hd);
        wr(8'h3c, 32'h01);
        settle;
        rd(8'h08, 32'h5, "pins zero");
        $display("test pin sharing done");
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h44, c);
            wr(8'h3c, c);
            wait_idle(8 * (4 << c));
            rd(8'h3c, 32'h80 | c, "flag");
            rd(8'h40, levels[8*c +: 8], "result");
            rd(8'h3c, c, "flag cleared");
        end
        $display("test conversion done");
        wr(8'h44, 32'h0);
        wr(8'h4c, 32'h1);
        wr(8'h3c, 32'h42);
        wait_idle(32);
        settle;
        `CHK("irq", 1'b1, irq)
        rd(8'h3c, 32'h42, "no flag");
        rd(8'h48, 32'h1, "irq status");
        wr(8'h4c, 32'h0);
        settle;
        `CHK("irq masked", 1'b0, irq)
        wr(8'h4c, 32'h1);
        settle;
        `CHK("irq unmasked", 1'b1, irq)
        wr(8'h48, 32'h1);
        settle;
        `CHK("irq cleared", 1'b0, irq)
        rd(8'h48, 32'h0, "irq status cleared");
        $display("test interrupt done");
        wr(8'h3c, 32'h23);
        repeat (20) @(posedge clk_sys);
        clk_en <= 1'b0;
        repeat (5) @(posedge clk_sys);
        clk_en <= 1'b1;
        repeat (80) @(posedge clk_sys);
        rd(8'h3c, 32'ha3, "continuous flag");
        rd(8'h40, 32'h81, "continuous result");
        repeat (80) @(posedge clk_sys);
        rd(8'h3c, 32'ha3, "continuous again");
        wr(8'h3c, 32'h07);
        settle;
        `CHK("mux off", 4'h0, selected_analog_input)
        `CHK("busy off", 1'b0, conv_busy)
        wr(8'h04, 32'h0);
        settle;
        rd(8'h08, 32'hf, "pins input");
        $display("test continuous done");
        summarize;
    end
endmodule // adc_channel_pin_control_tb
